// [shared/dprc_defs.svh]
// Constants for the DRAM page and refresh controller.
// What this block does
// - Burst only when burst_select is set.
// - Same row repeats only two column states.
// - Burst accesses keep configured column waits.
// - Row compare bounds follow mode and width.
// - Row hold keeps strobe low between spaces.
// - Held row strobe releases on listed events.
// - Without row hold, other space releases row.
// - Refresh cycles only when enable is set.
// - Counter matches constant, requests, restarts zero.
// - Refresh runs after request and bus grant.
// - Counter starts when clock select nonzero.
// - Extra requests while pending are discarded.
// - Refresh is precharge plus two strobe states.
// - Double precharge delays row strobe once.
// - Stretch adds one wait, refresh only.
// - Refresh length ignores access waits; only stretch and double precharge lengthen it.
// - Self refresh asserts strobes in standby.
// - Refresh pin driven only when enabled.
// - Refresh pin low during refresh cycles.
// - Full access is four states.
// - Match flag set on counter match.
// - Request during bus release runs once after.
`ifndef DPRC_DEFS_SVH
`define DPRC_DEFS_SVH
`define DPRC_ADDR_CTRL1 8'h00
`define DPRC_ADDR_CTRL2 8'h04
`define DPRC_ADDR_TCTRL 8'h08
`define DPRC_ADDR_COUNT 8'h0C
`define DPRC_ADDR_CONST 8'h10
`define DPRC_C1_BURST 0
`define DPRC_C1_HOLD 1
`define DPRC_C1_SELF 2
`define DPRC_C1_PIN 3
`define DPRC_C2_REFEN 0
`define DPRC_C2_TPC 1
`define DPRC_C2_STRETCH 2
`define DPRC_C2_COLLO 3
`define DPRC_C2_COLHI 4
`define DPRC_C2_MODE16 5
`define DPRC_TC_CMF 7
`define DPRC_TC_CKS_LO 3
`define DPRC_CNT_ZERO 8'h00
`define DPRC_RESP_OKAY 2'h0
`define DPRC_RESP_SLVERR 2'h2
`endif

// [shared/dprc_pkg.sv]
// Types for the DRAM page and refresh controller.
package dprc_pkg;
  typedef enum logic [3:0] {
    DPRC_IDLE, DPRC_PRE, DPRC_PRE2, DPRC_ROW, DPRC_C1, DPRC_CW, DPRC_C2,
    DPRC_RP, DPRC_RP2, DPRC_R1, DPRC_RW, DPRC_R2, DPRC_SELF
  } dprc_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } dprc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dprc_axi_rsp_t;

  typedef struct packed {
    logic row_n;
    logic upper_col_strobe_n;
    logic lower_col_strobe_n;
    logic refresh_n;
  } dprc_pins_t;

  typedef struct packed {
    dprc_axi_rsp_t axi;
    dprc_pins_t pins;
    dprc_state_t st;
    logic [3:0] ctrl1;
    logic [5:0] ctrl2;
    logic [2:0] cks;
    logic compare_match_flag;
    logic [7:0] count;
    logic [7:0] konst;
    logic req_pend;
    logic [1:0] wcnt;
    logic row_open;
    logic [23:0] last_addr;
    logic acc_wr;
    logic acc_done;
    logic prev_dram;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
  } dprc_state_s_t;
endpackage : dprc_pkg

// [rtl/dprc_ctrl.sv]
// DRAM fast-page access sequencer with CAS-before-RAS refresh timer.
//
// Our own choices: register access over AXI4-Lite and the address map.
`include "dprc_defs.svh"
module dprc_ctrl import dprc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dprc_axi_req_t axi_req,
  output dprc_axi_rsp_t axi_rsp,
  input wire logic [7:0] tick_div,
  input wire logic acc_req,
  input wire logic acc_dram,
  input wire logic [23:0] acc_addr,
  input wire logic acc_wide,
  input wire logic [1:0] acc_waits,
  input wire logic bus_grant,
  input wire logic bus_release,
  input wire logic standby,
  output logic acc_ack,
  output logic refresh_busy,
  output dprc_pins_t pins
);
  // ****************************************
  // State.
  // ****************************************
  dprc_state_s_t s_r;
  dprc_state_s_t s_nxt;
  logic [7:0] div_r;
  logic tick;
  logic [3:0] lo_bit;
  logic [23:0] mask;
  logic row_hit;
  logic hold_mode;
  logic match_ev;
  logic aw_do;
  logic ar_do;
  logic [31:0] rd;

  assign axi_rsp = s_r.axi;
  assign pins = s_r.pins;
  assign acc_ack = s_r.acc_done;
  assign refresh_busy = s_r.req_pend;

  // ****************************************
  // Counter clock divider.
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 8'h00;
    end else if (tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  always_comb begin
    unique case (s_r.cks)
      3'h1: tick = (div_r[0] == 1'b1);
      3'h2: tick = (div_r[2:0] == 3'h7);
      3'h3: tick = (div_r[4:0] == 5'h1F);
      3'h4: tick = (div_r[6:0] == 7'h7F);
      3'h5: tick = (div_r == tick_div);
      3'h6: tick = (div_r == 8'hFF);
      3'h7: tick = (div_r == 8'hFF);
      default: tick = 1'b0;
    endcase
  end

  // ****************************************
  // Row compare.
  // ****************************************
  always_comb begin
    lo_bit = 4'h9 + {2'h0, s_r.ctrl2[`DPRC_C2_COLHI:`DPRC_C2_COLLO]}
      - {3'h0, ~acc_wide};
    mask = 24'hFFFFFF << lo_bit;
    if (!s_r.ctrl2[`DPRC_C2_MODE16]) begin
      mask = mask & 24'h0FFFFF;
    end
    row_hit = s_r.row_open && ((acc_addr & mask) == (s_r.last_addr & mask))
      && (s_r.ctrl2[`DPRC_C2_COLHI:`DPRC_C2_COLLO] != 2'h3);
  end
  assign hold_mode = s_r.ctrl1[`DPRC_C1_BURST] && s_r.ctrl1[`DPRC_C1_HOLD];
  assign match_ev = tick && (s_r.cks != 3'h0) && (s_r.count == s_r.konst);
  assign aw_do = (s_r.aw_got || axi_req.awvalid)
    && (s_r.w_got || axi_req.wvalid) && !s_r.axi.bvalid;
  assign ar_do = axi_req.arvalid && s_r.axi.arready;

  always_comb begin
    unique case (axi_req.araddr)
      `DPRC_ADDR_CTRL1: rd = {28'h0, s_r.ctrl1};
      `DPRC_ADDR_CTRL2: rd = {26'h0, s_r.ctrl2};
      `DPRC_ADDR_TCTRL: rd = {24'h0, s_r.compare_match_flag, 1'b0, s_r.cks, 3'h0};
      `DPRC_ADDR_COUNT: rd = {24'h0, s_r.count};
      `DPRC_ADDR_CONST: rd = {24'h0, s_r.konst};
      default: rd = 32'h0;
    endcase
  end

  // ****************************************
  // Next state.
  // ****************************************
  always_comb begin
    logic [7:0] wa;
    logic [31:0] wd;
    logic ok;
    wa = s_r.aw_got ? s_r.aw_a : axi_req.awaddr;
    wd = s_r.w_got ? s_r.w_d : axi_req.wdata;
    ok = s_r.w_got ? s_r.w_s[0] : axi_req.wstrb[0];
    s_nxt = s_r;
    s_nxt.acc_done = 1'b0;
    // Bus slave handshakes.
    s_nxt.axi.awready = !s_r.aw_got && !s_r.axi.bvalid;
    s_nxt.axi.wready = !s_r.w_got && !s_r.axi.bvalid;
    if (axi_req.awvalid && s_r.axi.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_a = axi_req.awaddr;
      s_nxt.axi.awready = 1'b0;
    end
    if (axi_req.wvalid && s_r.axi.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_d = axi_req.wdata;
      s_nxt.w_s = axi_req.wstrb;
      s_nxt.axi.wready = 1'b0;
    end
    if (s_r.axi.bvalid && axi_req.bready) begin
      s_nxt.axi.bvalid = 1'b0;
    end
    if (s_r.axi.rvalid && axi_req.rready) begin
      s_nxt.axi.rvalid = 1'b0;
      s_nxt.axi.arready = 1'b1;
    end
    // Counter increments on the selected clock and restarts on match.
    // counting start
    if (tick && s_r.cks != 3'h0) begin
      s_nxt.count = s_r.count + 8'h01;
    end
    if (match_ev) begin
      s_nxt.count = `DPRC_CNT_ZERO;
      if (!s_r.req_pend && s_r.st != DPRC_RP && s_r.st != DPRC_RP2
          && s_r.st != DPRC_R1 && s_r.st != DPRC_RW && s_r.st != DPRC_R2) begin
        s_nxt.req_pend = s_r.ctrl2[`DPRC_C2_REFEN];
      end
    end
    // Register writes; the hardware set of the flag wins over the clear.
    if (aw_do && (s_r.aw_got || s_r.axi.awready)
        && (s_r.w_got || s_r.axi.wready)) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.axi.bvalid = 1'b1;
      s_nxt.axi.bresp = `DPRC_RESP_OKAY;
      s_nxt.axi.awready = 1'b0;
      s_nxt.axi.wready = 1'b0;
      if (ok) begin
        unique case (wa)
          `DPRC_ADDR_CTRL1: begin
            s_nxt.ctrl1 = wd[3:0];
            if (s_r.st == DPRC_IDLE && ((s_r.ctrl1[`DPRC_C1_BURST]
                && !wd[`DPRC_C1_BURST])
                || (hold_mode && !wd[`DPRC_C1_HOLD]))) begin
              s_nxt.row_open = 1'b0;
              s_nxt.pins.row_n = 1'b1;
            end
          end
          `DPRC_ADDR_CTRL2: s_nxt.ctrl2 = wd[5:0];
          `DPRC_ADDR_TCTRL: begin
            s_nxt.cks = wd[5:3];
            if (!wd[`DPRC_TC_CMF]) begin
              s_nxt.compare_match_flag = 1'b0;
            end
          end
          `DPRC_ADDR_COUNT: s_nxt.count = wd[7:0];
          `DPRC_ADDR_CONST: s_nxt.konst = wd[7:0];
          default: s_nxt.axi.bresp = `DPRC_RESP_SLVERR;
        endcase
      end
    end
    if (match_ev) begin
      s_nxt.compare_match_flag = 1'b1;
    end
    if (ar_do) begin
      s_nxt.axi.arready = 1'b0;
      s_nxt.axi.rvalid = 1'b1;
      s_nxt.axi.rdata = rd;
      s_nxt.axi.rresp = (axi_req.araddr > `DPRC_ADDR_CONST
        || axi_req.araddr[1:0] != 2'h0) ? `DPRC_RESP_SLVERR
        : `DPRC_RESP_OKAY;
    end
    if (!hold_mode && s_r.st == DPRC_IDLE && !s_r.prev_dram) begin
      s_nxt.row_open = 1'b0;
      s_nxt.pins.row_n = 1'b1;
    end
    // Access and refresh sequencer.
    unique case (s_r.st)
      DPRC_IDLE: begin
        s_nxt.pins.refresh_n = 1'b1;
        if (standby && s_r.ctrl1[`DPRC_C1_SELF]) begin
          s_nxt.st = DPRC_SELF;
          s_nxt.pins.upper_col_strobe_n = 1'b0;
          s_nxt.pins.lower_col_strobe_n = 1'b0;
          s_nxt.row_open = 1'b0;
        end else if (bus_release || standby) begin
          s_nxt.pins.row_n = 1'b1;
          s_nxt.row_open = 1'b0;
        end else if (s_r.req_pend && bus_grant) begin
          s_nxt.pins.row_n = 1'b1;
          s_nxt.pins.upper_col_strobe_n = 1'b0;
          s_nxt.pins.lower_col_strobe_n = 1'b0;
          s_nxt.row_open = 1'b0;
          s_nxt.st = DPRC_RP;
        end else if (acc_req && acc_dram && !s_r.acc_done) begin
          s_nxt.acc_wr = acc_wide;
          s_nxt.prev_dram = 1'b1;
          if (s_r.ctrl1[`DPRC_C1_BURST] && row_hit) begin
            s_nxt.st = DPRC_C1;
          end else begin
            s_nxt.pins.row_n = 1'b1;
            s_nxt.st = DPRC_PRE;
          end
          s_nxt.last_addr = acc_addr;
          s_nxt.wcnt = acc_waits;
        end else if (acc_req && !s_r.acc_done) begin
          s_nxt.prev_dram = 1'b0;
          s_nxt.acc_done = 1'b1;
          if (!hold_mode) begin
            s_nxt.pins.row_n = 1'b1;
            s_nxt.row_open = 1'b0;
          end
        end
      end
      DPRC_PRE: begin
        s_nxt.st = s_r.ctrl2[`DPRC_C2_TPC] ? DPRC_PRE2 : DPRC_ROW;
      end
      DPRC_PRE2: s_nxt.st = DPRC_ROW;
      DPRC_ROW: begin
        s_nxt.pins.row_n = 1'b0;
        s_nxt.row_open = 1'b1;
        s_nxt.st = DPRC_C1;
      end
      DPRC_C1: begin
        s_nxt.pins.upper_col_strobe_n = 1'b0;
        s_nxt.pins.lower_col_strobe_n = !s_r.acc_wr;
        s_nxt.st = (s_r.wcnt != 2'h0) ? DPRC_CW : DPRC_C2;
      end
      DPRC_CW: begin
        s_nxt.wcnt = s_r.wcnt - 2'h1;
        s_nxt.st = (s_r.wcnt == 2'h1) ? DPRC_C2 : DPRC_CW;
      end
      DPRC_C2: begin
        s_nxt.pins.upper_col_strobe_n = 1'b1;
        s_nxt.pins.lower_col_strobe_n = 1'b1;
        s_nxt.acc_done = 1'b1;
        s_nxt.st = DPRC_IDLE;
        if (!s_r.ctrl1[`DPRC_C1_BURST]) begin
          s_nxt.pins.row_n = 1'b1;
          s_nxt.row_open = 1'b0;
        end
      end
      DPRC_RP: begin
        // Column strobes fell on entry; the row strobe follows precharge.
        if (!s_r.ctrl2[`DPRC_C2_TPC]) begin
          s_nxt.pins.row_n = 1'b0;
        end
        s_nxt.pins.refresh_n = !s_r.ctrl1[`DPRC_C1_PIN];
        s_nxt.st = s_r.ctrl2[`DPRC_C2_TPC] ? DPRC_RP2 : DPRC_R1;
      end
      DPRC_RP2: begin
        s_nxt.pins.row_n = 1'b0;
        s_nxt.st = DPRC_R1;
      end
      DPRC_R1: begin
        s_nxt.st = s_r.ctrl2[`DPRC_C2_STRETCH] ? DPRC_RW : DPRC_R2;
      end
      DPRC_RW: s_nxt.st = DPRC_R2;
      DPRC_R2: begin
        s_nxt.pins = '{row_n: 1'b1, upper_col_strobe_n: 1'b1, lower_col_strobe_n: 1'b1,
          refresh_n: 1'b1};
        s_nxt.req_pend = 1'b0;
        s_nxt.prev_dram = 1'b0;
        s_nxt.st = DPRC_IDLE;
      end
      DPRC_SELF: begin
        s_nxt.pins.row_n = 1'b0;
        if (!standby) begin
          s_nxt.pins.row_n = 1'b1;
          s_nxt.pins.upper_col_strobe_n = 1'b1;
          s_nxt.pins.lower_col_strobe_n = 1'b1;
          s_nxt.st = DPRC_IDLE;
        end
      end
      default: s_nxt.st = DPRC_IDLE;
    endcase
  end

  // ****************************************
  // Register.
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= DPRC_IDLE;
      s_r.axi.arready <= 1'b1;
      s_r.pins <= '{row_n: 1'b1, upper_col_strobe_n: 1'b1, lower_col_strobe_n: 1'b1,
        refresh_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : dprc_ctrl

// [tb/dprc_ctrl_properties.sv]
// Port checker for the DRAM page and refresh controller.
module dprc_ctrl_properties import dprc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic acc_req,
  input wire logic bus_grant,
  input wire logic bus_release,
  input wire logic standby,
  input wire logic acc_ack,
  input wire dprc_pins_t pins
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_cbr_start;
    $fell(pins.upper_col_strobe_n) && pins.row_n && !standby;
  endsequence
  sequence s_ras_pulse;
    !pins.row_n [*2] ##[1:2] pins.row_n;
  endsequence
  property p_full;
    $fell(pins.row_n) && pins.upper_col_strobe_n |=> !pins.upper_col_strobe_n;
  endproperty
  a_full: assert property (p_full)
    else $error("column state late");
  property p_ack;
    acc_ack |-> acc_req && !$past(acc_ack);
  endproperty
  a_ack: assert property (p_ack)
    else $error("stray access ack");
  property p_cbr;
    s_cbr_start |-> ##[1:2] !pins.row_n;
  endproperty
  a_cbr: assert property (p_cbr)
    else $error("refresh row strobe missing");
  property p_rowlen;
    $fell(pins.row_n) && !pins.upper_col_strobe_n && !standby |-> s_ras_pulse;
  endproperty
  a_rowlen: assert property (p_rowlen)
    else $error("refresh row strobe width");
  property p_grant;
    s_cbr_start |-> bus_grant || $past(bus_grant) || $past(bus_grant, 2);
  endproperty
  a_grant: assert property (p_grant)
    else $error("refresh without bus");
  property p_pin;
    !pins.refresh_n |-> !pins.upper_col_strobe_n;
  endproperty
  a_pin: assert property (p_pin)
    else $error("refresh pin outside refresh");
  property p_release;
    $rose(bus_release) |-> ##[0:6] pins.row_n;
  endproperty
  a_release: assert property (p_release)
    else $error("row held over release");
  property p_wake;
    $fell(standby) |-> ##[1:4] (pins.row_n && pins.upper_col_strobe_n);
  endproperty
  a_wake: assert property (p_wake)
    else $error("strobes low after wake");
endmodule : dprc_ctrl_properties

bind dprc_ctrl dprc_ctrl_properties chk_u (.aclk, .aresetn, .acc_req,
  .bus_grant, .bus_release, .standby, .acc_ack, .pins);

// [tb/dprc_dram_model.sv]
// Behavioural DRAM that counts row openings and refreshes.
module dprc_dram_model import dprc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dprc_pins_t pins,
  output logic [7:0] act_cnt,
  output logic [7:0] cbr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Strobe decode
  // ********
  logic row_q;
  logic cas_q;
  always @(posedge aclk) begin
    row_q <= pins.row_n;
    cas_q <= pins.upper_col_strobe_n;
    if (!aresetn) begin
      act_cnt <= 8'h00;
      cbr_cnt <= 8'h00;
    end else begin
      if (row_q && !pins.row_n && pins.upper_col_strobe_n) act_cnt <= act_cnt + 8'h01;
      if (cas_q && !pins.upper_col_strobe_n && pins.row_n) cbr_cnt <= cbr_cnt + 8'h01;
    end
  end
endmodule : dprc_dram_model

// [tb/tb_dram_page_refresh_ctrl.sv]
// Self-checking bench for the DRAM page and refresh controller.
module tb_dram_page_refresh_ctrl import dprc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bench
  // ********
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  dprc_axi_req_t rq = '0;
  dprc_axi_rsp_t rs;
  logic acc_req = 1'h0;
  logic acc_dram = 1'h0;
  logic [23:0] acc_addr = 24'h0;
  logic acc_wide = 1'h0;
  logic [1:0] acc_waits = 2'h0;
  logic bus_grant = 1'h1;
  logic bus_release = 1'h0;
  logic standby = 1'h0;
  logic acc_ack;
  dprc_pins_t pins;
  logic [7:0] act_cnt;
  logic [7:0] cbr_cnt;
  logic [31:0] d;
  logic [1:0] r;
  int fails = 0;
  int check_count = 0;
  int rf_low = 0;
  int b;
  int ea;
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (pins.refresh_n === 1'h0) rf_low++;
  end
  dprc_ctrl dut_u (.aclk, .aresetn, .axi_req(rq), .axi_rsp(rs),
    .tick_div(8'h03), .acc_req, .acc_dram, .acc_addr, .acc_wide,
    .acc_waits, .bus_grant, .bus_release, .standby, .acc_ack,
    .refresh_busy(), .pins);
  dprc_dram_model mem_u (.aclk, .aresetn, .pins, .act_cnt, .cbr_cnt);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic final_report;
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic tmo(input int n);
    if (n >= 60) begin
      fails++;
      final_report();
    end
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    rq.awvalid <= 1'h1;
    rq.awaddr <= a;
    rq.wvalid <= 1'h1;
    rq.wdata <= v;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (rs.awready === 1'h1) rq.awvalid <= 1'h0;
      if (rs.wready === 1'h1) rq.wvalid <= 1'h0;
      if (rs.bvalid === 1'h1) break;
    end
    rq.bready <= 1'h0;
    tmo(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    rq.arvalid <= 1'h1;
    rq.araddr <= a;
    rq.rready <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (rs.arready === 1'h1) rq.arvalid <= 1'h0;
      if (rs.rvalid === 1'h1) break;
    end
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'h0;
    tmo(n);
  endtask : rd
  task automatic acc(input logic [23:0] a, input logic dr, input logic w);
    int n;
    @(posedge aclk);
    acc_req <= 1'h1;
    acc_addr <= a;
    acc_dram <= dr;
    acc_wide <= w;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (acc_ack === 1'h1) break;
    end
    acc_req <= 1'h0;
    tmo(n);
  endtask : acc
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h14);
    check({r, d}, {2'h2, 32'h0});
    wr(8'h10, 32'h3);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h8);
    cyc(100);
    check(cbr_cnt, 8'h00);
    rd(8'h08);
    check(d[7], 1'h1);
    for (int i = 0; i < 2; i++) begin
      b = cbr_cnt;
      rf_low = 0;
      wr(8'h00, i ? 32'h8 : 32'h0);
      wr(8'h04, i ? 32'h7 : 32'h1);
      cyc(100);
      check(cbr_cnt > b, 1'h1);
      check(rf_low > 0, i);
    end
    bus_release <= 1'h1;
    bus_grant <= 1'h0;
    cyc(30);
    wr(8'h08, 32'h0);
    b = cbr_cnt;
    bus_release <= 1'h0;
    bus_grant <= 1'h1;
    cyc(40);
    check(cbr_cnt - b, 32'h1);
    wr(8'h10, 32'hFF);
    wr(8'h08, 32'h38);
    wr(8'h00, 32'h0);
    // row strobe released for other devices except in row hold mode
    acc_waits <= 2'h2;
    ea = act_cnt + 2;
    acc(24'h0, 1'h1, 1'h1);
    acc(24'h0, 1'h1, 1'h1);
    check(act_cnt, ea);
    wr(8'h00, 32'h1);
    acc(24'h0, 1'h1, 1'h1);
    acc(24'h100, 1'h1, 1'h1);
    acc(24'h0, 1'h1, 1'h0);
    acc(24'h100, 1'h1, 1'h0);
    check(act_cnt, ea + 3);
    acc(24'h4000, 1'h1, 1'h1);
    acc(24'h4000, 1'h0, 1'h1);
    acc(24'h4000, 1'h1, 1'h1);
    check(act_cnt, ea + 5);
    wr(8'h00, 32'h3);
    acc(24'h8000, 1'h1, 1'h1);
    acc(24'h8000, 1'h0, 1'h1);
    check(pins.row_n, 1'h0);
    acc(24'h8000, 1'h1, 1'h1);
    check(act_cnt, ea + 6);
    wr(8'h00, 32'h1);
    cyc(2);
    check(pins.row_n, 1'h1);
    acc(24'h0C000, 1'h1, 1'h1);
    acc(24'h10C000, 1'h1, 1'h1);
    wr(8'h04, 32'h21);
    acc(24'h20C000, 1'h1, 1'h1);
    check(act_cnt, ea + 8);
    wr(8'h00, 32'h4);
    standby <= 1'h1;
    cyc(10);
    check({pins.row_n, pins.upper_col_strobe_n}, 2'h0);
    standby <= 1'h0;
    cyc(10);
    check({pins.row_n, pins.upper_col_strobe_n}, 2'h3);
    final_report();
  end
endmodule : tb_dram_page_refresh_ctrl
